/* File: rtl/usb_ctrl_consts.vh */
`ifndef USB_CTRL_CONSTS_VH
`define USB_CTRL_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_FRAME_LOW 8'h31
`define IDX_FRAME_HIGH 8'h32
`define IDX_LINK_CTRL 8'h33
`define IDX_MANUAL_TX 8'h34
`define IDX_PIN_IO 8'h35
`define IDX_EP0_CTRL 8'h36

// Reset values
`define RST_LINK_CTRL 8'h00
`define RST_MANUAL_TX 8'h00
`define RST_PIN_IO_WR 8'h00
`define RST_EP0_CTRL 8'h00
`define RST_FRAME 11'h000

// Link control fields
`define LC_ENABLE 7
`define LC_ADDR_HI 6

// Manual transmit fields
`define MT_ENABLE 7
`define MT_SE0 6
`define MT_LINE 5
`define MT_RX 0

// Pin I/O fields
`define PIO_OVERRIDE 7
`define PIO_PUSHPULL 6
`define PIO_DP_OUT 5
`define PIO_DM_OUT 4
`define PIO_WEAK_PU 3
`define PIO_ATTACH_PU 2
`define PIO_DP_IN 1
`define PIO_DM_IN 0

// Endpoint-zero control fields
`define EP_SETUP 7
`define EP_IN 6
`define EP_OUT 5
`define EP_ACKED 4
`define EP_MODE_HI 3

// Handshake answer codes
`define HS_ACK 2'h0
`define HS_NAK 2'h1
`define HS_STALL 2'h2
`define HS_IGNORE 2'h3

// Default mode-to-handshake table, two bits per mode, mode 0 in the low bits
`define HS_TABLE_DEFAULT 32'hf6a5_9451

`endif

/* File: rtl/usb_device_ctrl_regs.v */
`timescale 1ns/10ps
`include "usb_ctrl_consts.vh"

module usb_device_ctrl_regs #(
    parameter [31:0] HS_TABLE = `HS_TABLE_DEFAULT
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire sof_valid,
    input wire [10:0] sof_frame,
    input wire bus_reset,
    input wire token_valid,
    input wire [6:0] token_addr,
    input wire setup_token,
    input wire setup_active,
    input wire in_acked,
    input wire out_acked,
    input wire trans_acked,
    input wire eng_update,
    input wire [3:0] eng_mode,
    input wire eng_dp,
    input wire eng_dm,
    input wire eng_oe,
    input wire dp_in,
    input wire dm_in,
    output reg link_enable_r,
    output reg [6:0] device_address_r,
    output reg token_match_r,
    output reg [3:0] ep0_mode_r,
    output reg [1:0] ep0_handshake_r,
    output reg ep0_ctrl_locked_r,
    output reg ep0_data_locked_r,
    output reg dp_out_r,
    output reg dp_oe_r,
    output reg dm_out_r,
    output reg dm_oe_r,
    output reg weak_pullup_r,
    output reg attach_pullup_r
);

    // Table lookup: two bits per mode
    // Mode n sits at bits 2n+1:2n of the table
    function [1:0] hs_of;
        input [31:0] tbl;
        input [3:0] mode;
        begin
            hs_of = tbl[{mode, 1'b0} +: 2];
        end
    endfunction

    // Register index decode from a byte address
    // Low address bits must be zero: only aligned word accesses hit a register
    function is_reg;
        input [7:0] addr;
        input [7:0] idx;
        begin
            is_reg = (addr[1:0] == 2'h0) && (addr[7:2] == idx[5:0]);
        end
    endfunction

    // Stored state and combinational next values
    reg [10:0] frame_r;
    reg [7:0] manual_tx_r;
    reg [7:0] pin_io_r;
    reg [3:0] ep0_flags_r;
    reg dp_nxt;
    reg dp_oe_nxt;
    reg dm_nxt;
    reg dm_oe_nxt;
    reg [31:0] rdata_nxt;
    reg hit;
    // Bus strobes and the live receiver bit
    wire access;
    wire wr;
    wire rd;
    wire ctrl_read;
    wire ctrl_write;
    wire rx_diff;

    // Access phase strobes; a locked control write is dropped without an error
    assign access = psel && penable;
    assign wr = access && pwrite;
    assign rd = access && !pwrite;
    assign ctrl_read = rd && is_reg(paddr, `IDX_EP0_CTRL);
    assign ctrl_write = wr && is_reg(paddr, `IDX_EP0_CTRL) && !ep0_ctrl_locked_r;
    assign rx_diff = dp_in && !dm_in;

    // Frame number capture from each start-of-frame packet
    // Low and high are read separately and may straddle a new frame
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            frame_r <= `RST_FRAME;
        else if (sof_valid)
            frame_r <= sof_frame;
    end

    // Link control: bus reset beats any firmware write
    // Hardware never loads an address; only a firmware write or a bus reset (to zero) changes it
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            link_enable_r <= 1'b0;
            device_address_r <= 7'h00;
        end
        else if (bus_reset)
        begin
            link_enable_r <= 1'b0;
            device_address_r <= 7'h00;
        end
        else if (wr && is_reg(paddr, `IDX_LINK_CTRL))
        begin
            link_enable_r <= pwdata[`LC_ENABLE];
            device_address_r <= pwdata[`LC_ADDR_HI:0];
        end
    end

    // Token filter: disabled link ignores all traffic
    // Registered, so the engine sees the match one cycle after the token
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            token_match_r <= 1'b0;
        else
            token_match_r <= link_enable_r && token_valid
                             && (token_addr == device_address_r);
    end

    // Software pin control registers; only writable bits are stored
    // Read-only bits are rebuilt from the live pins at read time
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            manual_tx_r <= `RST_MANUAL_TX;
            pin_io_r <= `RST_PIN_IO_WR;
        end
        else
        begin
            if (wr && is_reg(paddr, `IDX_MANUAL_TX))
                manual_tx_r <= {pwdata[7:5], 5'h00};
            if (wr && is_reg(paddr, `IDX_PIN_IO))
                pin_io_r <= {pwdata[7:2], 2'h0};
        end
    end

    // Pad drive selection; pin override outranks manual transmit
    // Bit-banged pins and manual transmit can never fight over a pad
    always @*
    begin
        dp_nxt = eng_dp;
        dm_nxt = eng_dm;
        dp_oe_nxt = eng_oe;
        dm_oe_nxt = eng_oe;
        if (pin_io_r[`PIO_OVERRIDE])
        begin
            dp_nxt = pin_io_r[`PIO_DP_OUT];
            dm_nxt = pin_io_r[`PIO_DM_OUT];
            // Open-drain releases a pad whose bit is one
            dp_oe_nxt = pin_io_r[`PIO_PUSHPULL] || !pin_io_r[`PIO_DP_OUT];
            dm_oe_nxt = pin_io_r[`PIO_PUSHPULL] || !pin_io_r[`PIO_DM_OUT];
        end
        else if (manual_tx_r[`MT_ENABLE])
        begin
            // Manual transmit always drives both pads
            dp_oe_nxt = 1'b1;
            dm_oe_nxt = 1'b1;
            if (manual_tx_r[`MT_SE0])
            begin
                dp_nxt = 1'b0;
                dm_nxt = 1'b0;
            end
            else
            begin
                dp_nxt = manual_tx_r[`MT_LINE];
                dm_nxt = !manual_tx_r[`MT_LINE];
            end
        end
    end

    // Registered pad and pull-up outputs
    // Costs a cycle of latency but keeps the pads free of decode glitches
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dp_out_r <= 1'b0;
            dm_out_r <= 1'b0;
            dp_oe_r <= 1'b0;
            dm_oe_r <= 1'b0;
            weak_pullup_r <= 1'b0;
            attach_pullup_r <= 1'b0;
        end
        else
        begin
            dp_out_r <= dp_nxt;
            dm_out_r <= dm_nxt;
            dp_oe_r <= dp_oe_nxt;
            dm_oe_r <= dm_oe_nxt;
            weak_pullup_r <= pin_io_r[`PIO_WEAK_PU];
            attach_pullup_r <= pin_io_r[`PIO_ATTACH_PU];
        end
    end

    // Control/count interlock: engine update sets, control read clears, set wins
    // A read racing an engine update must not lose the new lock
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ep0_ctrl_locked_r <= 1'b0;
        else if (eng_update)
            ep0_ctrl_locked_r <= 1'b1;
        else if (ctrl_read)
            ep0_ctrl_locked_r <= 1'b0;
    end

    // Data lock from setup decode; setup flag also blocks data writes
    // A read while setup is still flagged must leave the data locked
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ep0_data_locked_r <= 1'b0;
        else if (setup_token || setup_active)
            ep0_data_locked_r <= 1'b1;
        else if (ctrl_read && !ep0_flags_r[3])
            ep0_data_locked_r <= 1'b0;
        else if (ep0_flags_r[3])
            ep0_data_locked_r <= 1'b1;
    end

    // Endpoint-zero status flags and mode; hardware sets win over the write clear
    // A write can never wipe a flag raised in the same cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {ep0_flags_r, ep0_mode_r} <= `RST_EP0_CTRL;
        end
        else
        begin
            if (ctrl_write)
            begin
                ep0_flags_r <= 4'h0;
                ep0_mode_r <= pwdata[`EP_MODE_HI:0];
            end
            if (eng_update)
                ep0_mode_r <= eng_mode;
            if (setup_active)
                ep0_flags_r[3] <= 1'b1;
            if (in_acked)
                ep0_flags_r[2] <= 1'b1;
            if (out_acked)
                ep0_flags_r[1] <= 1'b1;
            if (trans_acked)
                ep0_flags_r[0] <= 1'b1;
        end
    end

    // Handshake answer follows the current mode
    // One cycle behind the mode; the engine must allow for that
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ep0_handshake_r <= `HS_IGNORE;
        else
            ep0_handshake_r <= hs_of(HS_TABLE, ep0_mode_r);
    end

    // Read mux; unmapped addresses read zero with an error
    // Shares the address decode with the write path
    always @*
    begin
        hit = 1'b1;
        rdata_nxt = 32'h0000_0000;
        if (is_reg(paddr, `IDX_FRAME_LOW))
            rdata_nxt[7:0] = frame_r[7:0];
        else if (is_reg(paddr, `IDX_FRAME_HIGH))
            rdata_nxt[2:0] = frame_r[10:8];
        else if (is_reg(paddr, `IDX_LINK_CTRL))
            rdata_nxt[7:0] = {link_enable_r, device_address_r};
        else if (is_reg(paddr, `IDX_MANUAL_TX))
            rdata_nxt[7:0] = {manual_tx_r[7:5], 4'h0, rx_diff};
        else if (is_reg(paddr, `IDX_PIN_IO))
            rdata_nxt[7:0] = {pin_io_r[7:2], dp_in, dm_in};
        else if (is_reg(paddr, `IDX_EP0_CTRL))
            rdata_nxt[7:0] = {ep0_flags_r, ep0_mode_r};
        else
            hit = 1'b0;
    end

    // APB answer: no wait states, pready and data valid in the first access cycle
    // Fixed zero-wait answer keeps the slave free of stall logic
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            prdata <= (psel && !penable && !pwrite) ? rdata_nxt : 32'h0000_0000;
        end
    end

endmodule

/* File: testbench/test_usb_device_ctrl_regs.sv */
`timescale 1ns/10ps
`include "usb_ctrl_consts.vh"
module test_usb_device_ctrl_regs;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0, rd;
    reg bus_reset = 0, token_valid = 0, setup_token = 0, setup_active = 0, err;
    reg in_acked = 0, out_acked = 0, trans_acked = 0, eng_update = 0;
    reg [6:0] token_addr = 7'h00;
    reg [3:0] eng_mode = 4'h0;
    reg [10:0] f;
    wire [31:0] prdata;
    wire pready, pslverr, sof_valid, dp_in, dm_in, link_enable_r, token_match_r;
    wire ep0_ctrl_locked_r, ep0_data_locked_r, dp_out_r, dp_oe_r, dm_out_r, dm_oe_r;
    wire weak_pullup_r, attach_pullup_r;
    wire [10:0] sof_frame;
    wire [6:0] device_address_r;
    wire [3:0] ep0_mode_r;
    wire [1:0] ep0_handshake_r;
    wire eng_dp = 1'b0, eng_dm = 1'b0, eng_oe = 1'b0;
    integer fail_count = 0, checks = 0, i, n;
    usb_device_ctrl_regs uut (.*);
    usb_host_model host (.*);
    always #20 pclk = ~pclk;
    task wrap_up;
    begin
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask
    task chk(input reg [31:0] got, input reg [31:0] exp);
    begin
        checks = checks + 1;
        if (got !== exp)
        begin
            fail_count = fail_count + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    // One APB transfer; held until pready is seen at a rising edge
    task apb(input reg w, input reg [7:0] a, input reg [31:0] d);
    begin
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            n = n + 1;
            @(posedge pclk);
        end
        if (n == 20)
        begin
            fail_count = fail_count + 1;
            wrap_up;
        end
        rd = prdata; err = pslverr;
        psel <= 0; penable <= 0;
    end
    endtask
    task rchk(input reg [7:0] a, input reg [31:0] exp);
    begin
        apb(0, a, 8'h00);
        chk(rd, exp);
    end
    endtask
    task tok(input reg [6:0] a, input reg exp);
    begin
        @(posedge pclk); token_addr <= a; token_valid <= 1;
        @(posedge pclk); token_valid <= 0;
        @(negedge pclk); chk(token_match_r, exp);
    end
    endtask
    initial begin #400000; fail_count = fail_count + 1; wrap_up; end
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        rchk(8'hc4, 0); rchk(8'hcc, 0); rchk(8'hd0, 0); rchk(8'hd4, 3); rchk(8'hd8, 0);
        apb(0, 8'hfc, 8'h00); chk(err, 1); chk(rd, 0);
        apb(1, 8'hcc, 8'h85); rchk(8'hcc, 32'h85);
        tok(7'h04, 0); tok(7'h05, 1); tok(7'h06, 0);
        @(posedge pclk); bus_reset <= 1;
        @(posedge pclk); bus_reset <= 0;
        rchk(8'hcc, 0); tok(7'h00, 0);
        // Manual line states: SE0 beats J/K, then J, then K
        for (i = 0; i < 3; i = i + 1)
        begin
            apb(1, 8'hd0, 24'h80a0e0 >> 8 * i);
            rchk(8'hd0, (24'h80a0e0 >> 8 * i) & 8'hff | (i == 1));
            chk({dp_oe_r, dm_oe_r, dp_out_r, dm_out_r}, 16'hdec >> 4 * i & 4'hf);
        end
        apb(1, 8'hd0, 8'h00);
        // Pin override: open-drain low, open-drain released, push-pull, pull-up only
        for (i = 0; i < 4; i = i + 1)
        begin
            apb(1, 8'hd4, 32'h08e0b08c >> 8 * i);
            rchk(8'hd4, (32'h08e0b08c >> 8 * i) & 8'hff | (24'b001110111000001100110011 >> 6 * i + 2) & 3);
            chk({dp_oe_r, dm_oe_r, dp_in, dm_in, weak_pullup_r, attach_pullup_r}, (24'b001110111000001100110011 >> 6 * i) & 6'h3f);
        end
        @(posedge pclk); eng_mode <= 4'h3; eng_update <= 1;
        @(posedge pclk); eng_update <= 0;
        apb(1, 8'hd8, 8'h05); rchk(8'hd8, 32'h03);
        apb(1, 8'hd8, 8'h05); rchk(8'hd8, 32'h05);
        chk(ep0_handshake_r, `HS_TABLE_DEFAULT >> 2 * 5 & 2'h3);
        @(posedge pclk); in_acked <= 1; out_acked <= 1; trans_acked <= 1;
        @(posedge pclk); in_acked <= 0; out_acked <= 0; trans_acked <= 0;
        rchk(8'hd8, 32'h75);
        apb(1, 8'hd8, 8'hfa); rchk(8'hd8, 32'h0a);
        // Clear attempt while a setup packet is in flight
        @(posedge pclk); setup_token <= 1;
        @(posedge pclk); setup_token <= 0; setup_active <= 1;
        apb(1, 8'hd8, 8'h0a);
        @(posedge pclk); setup_active <= 0;
        rchk(8'hd8, 32'h8a); chk(ep0_data_locked_r, 1);
        apb(1, 8'hd8, 8'h0a); rchk(8'hd8, 32'h0a);
        @(negedge pclk); chk(ep0_data_locked_r, 0);
        // Two frame markers, the second across the 11-bit wrap
        for (i = 0; i < 2; i = i + 1)
        begin
            n = 0;
            @(posedge pclk);
            while (sof_valid !== 1'b1 && n < 300)
            begin
                n = n + 1;
                @(posedge pclk);
            end
            if (n == 300)
            begin
                fail_count = fail_count + 1;
                wrap_up;
            end
            f = sof_frame;
            rchk(8'hc4, f[7:0]); rchk(8'hc8, f[10:8]);
        end
        wrap_up;
    end
endmodule

/* File: testbench/usb_device_ctrl_regs_sva.sv */
`timescale 1ns/10ps
module usb_regs_checker (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire bus_reset,
    input wire token_valid,
    input wire [6:0] token_addr,
    input wire setup_token,
    input wire setup_active,
    input wire eng_update,
    input wire link_enable_r,
    input wire [6:0] device_address_r,
    input wire token_match_r,
    input wire [3:0] ep0_mode_r,
    input wire ep0_ctrl_locked_r,
    input wire ep0_data_locked_r,
    input wire weak_pullup_r,
    input wire attach_pullup_r
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completed write access
    wire wr = psel && penable && pready && pwrite;
    a_bus_reset_clear: assert property (bus_reset |=> !link_enable_r && device_address_r == 7'h00)
        else $error("link control kept bits after bus reset");
    a_token_gate: assert property (token_valid && !link_enable_r |=> !token_match_r)
        else $error("token answered while disabled");
    a_token_match: assert property (token_valid |=> token_match_r == $past(link_enable_r && token_addr == device_address_r))
        else $error("token match wrong");
    a_addr_hold: assert property (!(wr && paddr == 8'hcc) && !bus_reset |=> $stable(device_address_r))
        else $error("address moved without a write");
    a_engine_lock: assert property (eng_update |=> ep0_ctrl_locked_r)
        else $error("control not locked after engine update");
    a_locked_refuse: assert property (ep0_ctrl_locked_r && wr && paddr == 8'hd8 && !eng_update |=> $stable(ep0_mode_r))
        else $error("locked control write took effect");
    a_setup_lock: assert property (setup_token |=> ep0_data_locked_r)
        else $error("data not locked at setup token");
    a_setup_hold: assert property (setup_active |=> ep0_data_locked_r)
        else $error("data not locked during setup");
    a_pullup_follow: assert property (wr && paddr == 8'hd4 |=> ##1 weak_pullup_r == $past(pwdata[3], 2) && attach_pullup_r == $past(pwdata[2], 2))
        else $error("pull-up enables do not follow write");
endmodule
bind usb_device_ctrl_regs usb_regs_checker chk (.*);

/* File: testbench/usb_host_model.sv */
`timescale 1ns/10ps
module usb_host_model #(
    parameter SOF_GAP = 100
) (
    input wire pclk,
    input wire presetn,
    input wire dp_out_r,
    input wire dp_oe_r,
    input wire dm_out_r,
    input wire dm_oe_r,
    output reg sof_valid,
    output reg [10:0] sof_frame,
    output wire dp_in,
    output wire dm_in
);
    integer cnt;
    // Released pads float up through the bus pull-ups
    assign dp_in = dp_oe_r ? dp_out_r : 1'b1;
    assign dm_in = dm_oe_r ? dm_out_r : 1'b1;
    // Frame marker once per shortened period; the third mark crosses the wrap
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 0;
            sof_valid <= 1'b0;
            sof_frame <= 11'h7fd;
        end
        else
        begin
            cnt <= (cnt == SOF_GAP - 1) ? 0 : cnt + 1;
            sof_valid <= (cnt == SOF_GAP - 1);
            if (cnt == SOF_GAP - 1)
                sof_frame <= sof_frame + 11'h001;
        end
    end
endmodule
